//--- jtd_pkg.sv
package jtd_pkg;
  localparam int LANES = 8;
  localparam int OCT_MAX = 8;
  localparam int OCT_BITS = 8;
  localparam int BUF_BYTES = LANES * OCT_MAX;
  localparam int FRAME_BITS = BUF_BYTES * OCT_BITS;
  localparam int ADDR_W = 12;
  localparam int SMP_W = 16;
  localparam int DUAL_MAX_LANES = 4;
  // Register map
  localparam logic [11:0] ADDR_MODE = 12'h110;
  localparam logic [11:0] ADDR_LANE_PD = 12'h201;
  localparam logic [11:0] ADDR_PAGE = 12'h300;
  localparam logic [11:0] ADDR_DID = 12'h450;
  localparam logic [11:0] ADDR_BID = 12'h451;
  localparam logic [11:0] ADDR_LANE_ZERO_IDENTIFIER_MATCH = 12'h452;
  localparam logic [11:0] ADDR_LM1 = 12'h453;
  localparam logic [11:0] ADDR_FM1 = 12'h454;
  localparam logic [11:0] ADDR_KM1 = 12'h455;
  localparam logic [11:0] ADDR_MM1 = 12'h456;
  localparam logic [11:0] ADDR_NM1 = 12'h457;
  localparam logic [11:0] ADDR_NPM1 = 12'h458;
  localparam logic [11:0] ADDR_SV = 12'h459;
  localparam logic [11:0] ADDR_HD = 12'h45A;
  localparam logic [11:0] ADDR_DESKEW = 12'h46C;
  // Field positions and fixed values
  localparam int MODE_DUAL_BIT = 7;
  localparam int PAGE_SEL_BIT = 2;
  localparam int CFG_OK_BIT = 7;
  localparam int HD_BIT = 7;
  localparam int VER_LSB = 5;
  localparam logic [4:0] K_M1_FIXED = 5'h1F;
  localparam logic [2:0] VER_B = 3'h1;
  localparam logic [4:0] NP12_M1 = 5'h0B;
  localparam logic [4:0] NP16_M1 = 5'h0F;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [1:0] {DF_IDLE = 2'b00, DF_RX = 2'b01, DF_UNPACK = 2'b10} jtd_rx_state_t;
  typedef enum logic {TX_FILL = 1'b0, TX_SEND = 1'b1} jtd_tx_state_t;

  // Lane count of a mode; zero marks a mode the link type does not offer
  function automatic logic [3:0] jtd_mode_lanes(input logic [4:0] mode, input logic dual);
    logic [3:0] n;
    case (mode)
      5'h00, 5'h05, 5'h07: n = 4'h1;
      5'h01, 5'h03, 5'h06: n = 4'h2;
      5'h02: n = 4'h3;
      5'h04, 5'h08, 5'h09, 5'h12, 5'h13, 5'h16: n = 4'h4;
      5'h0A, 5'h0B, 5'h0C, 5'h14, 5'h15: n = dual ? 4'h0 : 4'h8;
      default: n = 4'h0;
    endcase
    return n;
  endfunction : jtd_mode_lanes

  // Modes carrying 12-bit samples
  function automatic logic jtd_mode_np12(input logic [4:0] mode);
    return (mode == 5'h05) || (mode == 5'h06) || (mode == 5'h0C) || (mode == 5'h16);
  endfunction : jtd_mode_np12
endpackage : jtd_pkg

//--- jtd_link_if.sv
// Parallel octet link, one octet per lane per clock, ready is per lane
interface jtd_link_if #(parameter int LANES = jtd_pkg::LANES);
  logic [LANES-1:0][7:0] data;
  logic [LANES-1:0] valid;
  logic [LANES-1:0] sof;
  logic [LANES-1:0] ready;
  modport tx (output data, output valid, output sof, input ready);
  modport rx (input data, input valid, input sof, output ready);
endinterface : jtd_link_if

//--- jtd_tx.sv
module jtd_tx (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [2:0] TX_LM1_IN,
  input wire logic [2:0] TX_FM1_IN,
  input wire logic [7:0] TX_MM1_IN,
  input wire logic [2:0] TX_SM1_IN,
  input wire logic [4:0] TX_NPM1_IN,
  input wire logic [jtd_pkg::SMP_W-1:0] TX_SAMPLE_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  jtd_link_if.tx LINK
);
  import jtd_pkg::*;

  jtd_tx_state_t st_reg, st_next;
  logic [FRAME_BITS-1:0] vec_reg, vec_next;
  logic [10:0] scnt_reg, scnt_next;
  logic [3:0] lc_reg [LANES];
  logic [3:0] lc_next [LANES];
  logic [LANES-1:0] vld_reg, vld_next, sof_reg, sof_next;
  logic [LANES-1:0][7:0] dat_reg, dat_next;
  logic rdy_reg, rdy_next;

  // Frame packing and octet sending; the user must hold the config inputs steady
  always_comb begin
    int nsamp;
    int tbits;
    int np;
    int f;
    int sh;
    logic done;
    nsamp = (int'(TX_MM1_IN) + 1) * (int'(TX_SM1_IN) + 1);
    tbits = (int'(TX_LM1_IN) + 1) * (int'(TX_FM1_IN) + 1) * OCT_BITS;
    np = int'(TX_NPM1_IN) + 1;
    f = int'(TX_FM1_IN) + 1;
    sh = 0;
    done = 1'b1;
    st_next = st_reg;
    vec_next = vec_reg;
    scnt_next = scnt_reg;
    lc_next = lc_reg;
    case (st_reg)
      TX_FILL: begin
        if (TX_VALID_IN && rdy_reg) begin
          // Only the top NP bits go out, so the NP-N bits below N carry sample bits as they stand, not zeros
          vec_next = (vec_reg << np) | FRAME_BITS'(TX_SAMPLE_IN >> (SMP_W - np));
          scnt_next = scnt_reg + 11'h001;
          if (int'(scnt_next) == nsamp) begin
            st_next = TX_SEND;
            lc_next = '{default: 4'h0};
          end
        end
      end
      TX_SEND: begin
        for (int l = 0; l < LANES; l++) begin
          if (vld_reg[l] && LINK.ready[l]) begin
            lc_next[l] = lc_reg[l] + 4'h1;
          end
          if (l <= int'(TX_LM1_IN) && int'(lc_next[l]) != f) begin
            done = 1'b0;
          end
        end
        if (done) begin
          st_next = TX_FILL;
          scnt_next = '0;
          vec_next = '0;
        end
      end
      default: st_next = TX_FILL;
    endcase
    // Lane l carries frame octets l*F .. l*F+F-1, MSB of the frame first
    for (int l = 0; l < LANES; l++) begin
      vld_next[l] = (st_next == TX_SEND) && (l <= int'(TX_LM1_IN)) && (int'(lc_next[l]) < f);
      sof_next[l] = (lc_next[l] == 4'h0);
      sh = tbits - OCT_BITS * (l * f + int'(lc_next[l]) + 1);
      dat_next[l] = (sh >= 0) ? 8'(vec_next >> sh) : 8'h00;
    end
    rdy_next = (st_next == TX_FILL) && (int'(scnt_next) < nsamp);
  end

  // State registers
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_reg <= TX_FILL;
      vec_reg <= '0;
      scnt_reg <= '0;
      lc_reg <= '{default: 4'h0};
      vld_reg <= '0;
      sof_reg <= '0;
      dat_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      vec_reg <= vec_next;
      scnt_reg <= scnt_next;
      lc_reg <= lc_next;
      vld_reg <= vld_next;
      sof_reg <= sof_next;
      dat_reg <= dat_next;
      rdy_reg <= rdy_next;
    end
  end

  assign TX_READY_OUT = rdy_reg;
  assign LINK.valid = vld_reg;
  assign LINK.sof = sof_reg;
  assign LINK.data = dat_reg;
endmodule : jtd_tx

//--- jtd_rx.sv
// What this block does
// - Deframe received frames into converter sample words
// - Octets per lane per frame: 1,2,3,4,8
// - Frames per multiframe fixed at 32
// - Link uses 1,2,3,4 or 8 lanes
// - Converter count means real or I/Q streams
// - Samples per converter per frame: 1,2,4,8
// - No control words or bits; all data
// - High density bit 7 must be one
// - Single-link modes 0-12, 18-22 with table sets
// - Dual-link modes 0-9,18,19,22, four lanes max
// - Lanes, octets, multiframe held as minus-one fields
// - M, N, NP, S held as minus-one fields
// - Software matches device and bank identifiers
// - Software matches lane zero identifier
// - Three-bit version field, 0 or 1
// - Truncate samples to N, drop low bits
// - Zero or full padding gives same result
// - Deskew enabled, powered lanes of link zero whose page-zero deskew bit is set, after configuration
// - Lane enables follow selected mode lane count
// - Lanes powered after reset; one powers down
// - Page bit picks link for lane settings
// - Deskew bit includes logical lane in deskew
module jtd_rx (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [jtd_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  jtd_link_if.rx LINK,
  output logic [jtd_pkg::SMP_W-1:0] SAMPLE_OUT,
  output logic [7:0] SAMPLE_CONV_OUT,
  output logic [2:0] SAMPLE_IDX_OUT,
  output logic SAMPLE_VALID_OUT,
  input wire logic SAMPLE_READY_IN,
  output logic [jtd_pkg::LANES-1:0] LANE_ENABLE_OUT,
  output logic [jtd_pkg::LANES-1:0] LANE_POWER_DOWN_OUT,
  output logic CONFIG_OK_OUT
);
  import jtd_pkg::*;

  logic [4:0] mode_reg, mode_next, lid_reg, lid_next, lm1_reg, lm1_next, km1_reg, km1_next;
  logic [4:0] nm1_reg, nm1_next, npm1_reg, npm1_next, sm1_reg, sm1_next;
  logic [7:0] pd_reg, pd_next, did_reg, did_next, bid_reg, bid_next;
  logic [7:0] fm1_reg, fm1_next, mm1_reg, mm1_next, rdata_reg, rdata_next;
  logic [2:0] ver_reg, ver_next;
  logic dual_reg, dual_next, page_reg, page_next, hd_reg, hd_next, rvalid_reg;
  logic [1:0][7:0] dsk_reg, dsk_next;
  logic [3:0] mode_l;
  logic [LANES-1:0] en_mask, incl, lane_en_reg, lane_en_next;
  logic cfg_ok, cfg_ok_reg;

  // Register file: writes and readback
  always_comb begin
    mode_next = mode_reg;
    dual_next = dual_reg;
    pd_next = pd_reg;
    page_next = page_reg;
    did_next = did_reg;
    bid_next = bid_reg;
    lid_next = lid_reg;
    lm1_next = lm1_reg;
    fm1_next = fm1_reg;
    km1_next = km1_reg;
    mm1_next = mm1_reg;
    nm1_next = nm1_reg;
    npm1_next = npm1_reg;
    sm1_next = sm1_reg;
    ver_next = ver_reg;
    hd_next = hd_reg;
    dsk_next = dsk_reg;
    rdata_next = REG_RST;
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        ADDR_MODE: begin
          mode_next = REG_WDATA_IN[4:0];
          dual_next = REG_WDATA_IN[MODE_DUAL_BIT];
        end
        ADDR_LANE_PD: pd_next = REG_WDATA_IN;
        ADDR_PAGE: page_next = REG_WDATA_IN[PAGE_SEL_BIT];
        ADDR_DID: did_next = REG_WDATA_IN;
        ADDR_BID: bid_next = REG_WDATA_IN;
        ADDR_LANE_ZERO_IDENTIFIER_MATCH: lid_next = REG_WDATA_IN[4:0];
        ADDR_LM1: lm1_next = REG_WDATA_IN[4:0];
        ADDR_FM1: fm1_next = REG_WDATA_IN;
        ADDR_KM1: km1_next = REG_WDATA_IN[4:0];
        ADDR_MM1: mm1_next = REG_WDATA_IN;
        ADDR_NM1: nm1_next = REG_WDATA_IN[4:0];
        ADDR_NPM1: npm1_next = REG_WDATA_IN[4:0];
        ADDR_SV: begin
          sm1_next = REG_WDATA_IN[4:0];
          ver_next = REG_WDATA_IN[7:VER_LSB];
        end
        ADDR_HD: hd_next = REG_WDATA_IN[HD_BIT];
        ADDR_DESKEW: dsk_next[page_reg] = REG_WDATA_IN;
        default: ;
      endcase
    end
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        ADDR_MODE: rdata_next = {dual_reg, 2'h0, mode_reg};
        ADDR_LANE_PD: rdata_next = pd_reg;
        ADDR_PAGE: rdata_next = {cfg_ok_reg, 4'h0, page_reg, 2'h0};
        ADDR_DID: rdata_next = did_reg;
        ADDR_BID: rdata_next = bid_reg;
        ADDR_LANE_ZERO_IDENTIFIER_MATCH: rdata_next = {3'h0, lid_reg};
        ADDR_LM1: rdata_next = {3'h0, lm1_reg};
        ADDR_FM1: rdata_next = fm1_reg;
        ADDR_KM1: rdata_next = {3'h0, km1_reg};
        ADDR_MM1: rdata_next = mm1_reg;
        ADDR_NM1: rdata_next = {3'h0, nm1_reg};
        ADDR_NPM1: rdata_next = {3'h0, npm1_reg};
        ADDR_SV: rdata_next = {ver_reg, sm1_reg};
        ADDR_HD: rdata_next = {hd_reg, 7'h00};
        ADDR_DESKEW: rdata_next = dsk_reg[page_reg];
        default: rdata_next = REG_RST;
      endcase
    end
  end

  // Configuration check; the deframer only runs on a consistent set
  always_comb begin
    int have;
    int need;
    logic f_ok;
    logic s_ok;
    have = (int'(lm1_reg) + 1) * (int'(fm1_reg) + 1) * OCT_BITS;
    need = (int'(mm1_reg) + 1) * (int'(sm1_reg) + 1) * (int'(npm1_reg) + 1);
    f_ok = (fm1_reg <= 8'h03) || (fm1_reg == 8'h07);
    s_ok = (sm1_reg <= 5'h01) || (sm1_reg == 5'h03) || (sm1_reg == 5'h07);
    mode_l = jtd_mode_lanes(mode_reg, dual_reg);
    cfg_ok = hd_reg && (mode_l != 4'h0) && (int'(lm1_reg) + 1 == int'(mode_l))
      && (km1_reg == K_M1_FIXED) && (ver_reg <= VER_B) && f_ok && s_ok
      && (npm1_reg == (jtd_mode_np12(mode_reg) ? NP12_M1 : NP16_M1)) && (nm1_reg <= npm1_reg)
      && (have == need) && (have <= FRAME_BITS);
    en_mask = LANES'((LANES'(1) << mode_l) - LANES'(1));
    lane_en_next = dual_reg ? LANES'(en_mask | (en_mask << DUAL_MAX_LANES)) : en_mask;
    incl = cfg_ok ? (en_mask & dsk_reg[0] & ~pd_reg) : '0;
  end

  jtd_rx_state_t st_reg, st_next;
  logic [3:0] cnt_reg [LANES];
  logic [3:0] cnt_next [LANES];
  logic [7:0] frm_reg [BUF_BYTES];
  logic [7:0] frm_next [BUF_BYTES];
  logic [LANES-1:0] rdy_reg, rdy_next;
  logic [8:0] pos_reg, pos_next;
  logic [7:0] conv_reg, conv_next;
  logic [2:0] sidx_reg, sidx_next;
  logic [26:0] e0_reg, e0_next, e1_reg, e1_next;
  logic v0_reg, v0_next, v1_reg, v1_next;

  // Deframer: gather one frame per lane, then unpack samples into a two-entry buffer
  always_comb begin
    int idx;
    logic [5:0] b;
    logic [23:0] win;
    logic [26:0] ent;
    logic push;
    logic pop;
    logic done;
    logic start_ok;
    idx = 0;
    st_next = st_reg;
    cnt_next = cnt_reg;
    frm_next = frm_reg;
    pos_next = pos_reg;
    conv_next = conv_reg;
    sidx_next = sidx_reg;
    e0_next = e0_reg;
    e1_next = e1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    pop = v0_reg && SAMPLE_READY_IN;
    push = 1'b0;
    done = 1'b1;
    // Lanes start a frame together only when all included lanes offer a frame start
    start_ok = &((LINK.valid & LINK.sof) | ~incl);
    b = pos_reg[8:3];
    win = {frm_reg[b], frm_reg[6'(b + 6'h01)], frm_reg[6'(b + 6'h02)]};
    win = win << pos_reg[2:0];
    // Low NP-N bits cleared whatever arrived, so padding content never matters
    ent = {conv_reg, sidx_reg, win[23:8] & ~({SMP_W{1'b1}} >> (nm1_reg + 5'h01))};
    case (st_reg)
      DF_IDLE: begin
        if (cfg_ok) begin
          st_next = DF_RX;
          cnt_next = '{default: 4'h0};
        end
      end
      DF_RX: begin
        for (int l = 0; l < LANES; l++) begin
          if (LINK.valid[l] && rdy_reg[l]) begin
            idx = l * (int'(fm1_reg) + 1) + int'(cnt_reg[l]);
            frm_next[6'(idx)] = LINK.data[l];
            cnt_next[l] = cnt_reg[l] + 4'h1;
          end
          if (incl[l] && (int'(cnt_next[l]) != int'(fm1_reg) + 1)) begin
            done = 1'b0;
          end
        end
        if (done && (incl != '0)) begin
          st_next = DF_UNPACK;
          pos_next = '0;
          conv_next = '0;
          sidx_next = '0;
        end
      end
      DF_UNPACK: begin
        if (!v1_reg || pop) begin
          push = 1'b1;
          pos_next = pos_reg + 9'(npm1_reg) + 9'h001;
          if ({2'h0, sidx_reg} == sm1_reg) begin
            sidx_next = '0;
            conv_next = conv_reg + 8'h01;
            if (conv_reg == mm1_reg) begin
              st_next = DF_RX;
              cnt_next = '{default: 4'h0};
            end
          end else begin
            sidx_next = sidx_reg + 3'h1;
          end
        end
      end
      default: st_next = DF_IDLE;
    endcase
    if (!cfg_ok) begin
      st_next = DF_IDLE;
    end
    // Shift buffer: the head entry is always the output register
    if (pop) begin
      e0_next = e1_reg;
      v0_next = v1_reg;
      v1_next = 1'b0;
    end
    if (push) begin
      if (v0_next) begin
        e1_next = ent;
        v1_next = 1'b1;
      end else begin
        e0_next = ent;
        v0_next = 1'b1;
      end
    end
    // Ready is registered, so it is computed from the counts after this cycle
    for (int l = 0; l < LANES; l++) begin
      rdy_next[l] = (st_next == DF_RX) && incl[l] && ((cnt_next[l] == 4'h0) ? start_ok :
        (int'(cnt_next[l]) < int'(fm1_reg) + 1));
    end
  end

  // All state registers
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      {mode_reg, lid_reg, lm1_reg, km1_reg, nm1_reg, npm1_reg, sm1_reg} <= '0;
      pd_reg <= REG_RST;
      {did_reg, bid_reg, fm1_reg, mm1_reg, rdata_reg} <= '0;
      {ver_reg, dual_reg, page_reg, hd_reg, rvalid_reg, cfg_ok_reg} <= '0;
      dsk_reg <= '0;
      lane_en_reg <= '0;
      st_reg <= DF_IDLE;
      cnt_reg <= '{default: 4'h0};
      frm_reg <= '{default: 8'h00};
      rdy_reg <= '0;
      {pos_reg, conv_reg, sidx_reg} <= '0;
      {e0_reg, e1_reg, v0_reg, v1_reg} <= '0;
    end else begin
      {mode_reg, lid_reg, lm1_reg, km1_reg} <= {mode_next, lid_next, lm1_next, km1_next};
      {nm1_reg, npm1_reg, sm1_reg} <= {nm1_next, npm1_next, sm1_next};
      {pd_reg, did_reg, bid_reg, fm1_reg, mm1_reg} <= {pd_next, did_next, bid_next, fm1_next, mm1_next};
      {ver_reg, dual_reg, page_reg, hd_reg} <= {ver_next, dual_next, page_next, hd_next};
      rdata_reg <= rdata_next;
      rvalid_reg <= REG_RD_IN;
      cfg_ok_reg <= cfg_ok;
      dsk_reg <= dsk_next;
      lane_en_reg <= lane_en_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      frm_reg <= frm_next;
      rdy_reg <= rdy_next;
      {pos_reg, conv_reg, sidx_reg} <= {pos_next, conv_next, sidx_next};
      {e0_reg, e1_reg, v0_reg, v1_reg} <= {e0_next, e1_next, v0_next, v1_next};
    end
  end

  assign REG_RDATA_OUT = rdata_reg;
  assign REG_RVALID_OUT = rvalid_reg;
  assign LINK.ready = rdy_reg;
  assign SAMPLE_OUT = e0_reg[15:0];
  assign SAMPLE_IDX_OUT = e0_reg[18:16];
  assign SAMPLE_CONV_OUT = e0_reg[26:19];
  assign SAMPLE_VALID_OUT = v0_reg;
  assign LANE_ENABLE_OUT = lane_en_reg;
  assign LANE_POWER_DOWN_OUT = pd_reg;
  assign CONFIG_OK_OUT = cfg_ok_reg;
endmodule : jtd_rx

//--- jtd_asserts.sv
module jtd_asserts (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [jtd_pkg::LANES-1:0][7:0] data,
  input wire logic [jtd_pkg::LANES-1:0] valid,
  input wire logic [jtd_pkg::LANES-1:0] sof,
  input wire logic [jtd_pkg::LANES-1:0] ready
);
  import jtd_pkg::*;
  // One clock domain, so clock and reset are stated once
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // An octet offered on lane zero that is not yet granted
  sequence s_wait;
    valid[0] && !ready[0];
  endsequence
  // Longest grant a frame may need: eight octets per lane
  sequence s_long;
    ready[0] [*8];
  endsequence

  hold_offer_a: assert property (s_wait |=> valid[0] && $stable(data[0]) && $stable(sof[0]))
    else $error("link octet changed before it was taken");
  start_seen_a: assert property (((ready & ~$past(ready)) & ~$past(valid & sof)) == '0)
    else $error("lane granted without a frame start seen");
  grant_offer_a: assert property ($rose(ready[0]) |-> valid[0] && sof[0])
    else $error("grant rose while no frame start was offered");
  lane_order_a: assert property ($rose(|ready) |-> (ready & (ready + 1'b1)) == '0)
    else $error("granted lanes are not lanes zero upward");
  sof_once_a: assert property (ready[0] && $past(ready[0]) && valid[0] |-> !sof[0])
    else $error("frame start flag inside a frame");
  grant_len_a: assert property (s_long |=> !ready[0])
    else $error("grant longer than eight octets");
  fall_together_a: assert property ($fell(ready[0]) |-> ready == '0)
    else $error("lanes did not end the frame together");
  unpack_gap_a: assert property ($fell(ready[0]) |=> !ready[0])
    else $error("new grant without an unpack cycle");
  sof_aligned_a: assert property (valid[0] && sof[0] |-> (valid & sof) == valid)
    else $error("frame start not aligned across lanes");
endmodule : jtd_asserts

//--- tb_jesd_transport_deframer.sv
module tb_jesd_transport_deframer;
  timeunit 1ns;
  timeprecision 1ns;
  import jtd_pkg::*;
  typedef struct {logic [7:0] mode; int l; int f; int m; int s; int np; int n;} jtd_row_t;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic s_ready = 1'b0;
  logic [2:0] t_lm1 = 3'h0, t_fm1 = 3'h0, t_sm1 = 3'h0;
  logic [7:0] t_mm1 = 8'h00;
  logic [4:0] t_npm1 = 5'h00;
  logic [15:0] t_smp = 16'h0000;
  logic t_valid = 1'b0;
  logic [7:0] reg_rdata, lane_en, lane_pd, s_conv, v;
  logic reg_rvalid, s_valid, cfg_ok, tx_ready;
  logic [15:0] s_data;
  logic [2:0] s_idx;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  logic [26:0] expq[$];
  // Table modes: mode, L, F, M, S, NP, N; row two narrows N to expose truncation
  jtd_row_t rows[7] = '{'{8'h03, 2, 2, 2, 1, 16, 16}, '{8'h05, 1, 3, 2, 1, 12, 10}, '{8'h13, 4, 2, 1, 4, 16, 16},
    '{8'h16, 4, 3, 2, 4, 12, 12}, '{8'h07, 1, 8, 4, 1, 16, 16}, '{8'h0B, 8, 2, 2, 4, 16, 16},
    '{8'h02, 3, 4, 6, 1, 16, 16}};
  // Address, value that spoils the mode three set, value that restores it
  logic [27:0] bad[8] = '{{ADDR_HD, 8'h00, 8'h80}, {ADDR_KM1, 8'h0F, 8'h1F}, {ADDR_SV, 8'h40, 8'h20},
    {ADDR_MODE, 8'h8B, 8'h03}, {ADDR_FM1, 8'h02, 8'h01}, {ADDR_NPM1, 8'h0B, 8'h0F}, {ADDR_SV, 8'h22, 8'h20},
    {ADDR_LM1, 8'h02, 8'h01}};

  jtd_link_if jtd_link_if_inst ();
  jtd_tx jtd_tx_inst (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .TX_LM1_IN(t_lm1), .TX_FM1_IN(t_fm1),
    .TX_MM1_IN(t_mm1), .TX_SM1_IN(t_sm1), .TX_NPM1_IN(t_npm1), .TX_SAMPLE_IN(t_smp), .TX_VALID_IN(t_valid),
    .TX_READY_OUT(tx_ready), .LINK(jtd_link_if_inst.tx));
  jtd_rx jtd_rx_inst (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
    .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .REG_RVALID_OUT(reg_rvalid),
    .LINK(jtd_link_if_inst.rx), .SAMPLE_OUT(s_data), .SAMPLE_CONV_OUT(s_conv), .SAMPLE_IDX_OUT(s_idx),
    .SAMPLE_VALID_OUT(s_valid), .SAMPLE_READY_IN(s_ready), .LANE_ENABLE_OUT(lane_en),
    .LANE_POWER_DOWN_OUT(lane_pd), .CONFIG_OK_OUT(cfg_ok));
  jtd_asserts jtd_asserts_inst (.CORE_CLK_IN(core_clk), .RST_N_IN(rst_n), .data(jtd_link_if_inst.data),
    .valid(jtd_link_if_inst.valid), .sof(jtd_link_if_inst.sof), .ready(jtd_link_if_inst.ready));

  always #50 core_clk = ~core_clk;

  // Receiver stalls three cycles in seven so the two-entry buffer fills and backs up
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    #1 s_ready = (cyc % 7) < 4;
  end

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_smp(input logic [26:0] got, input logic [26:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: sample/conv/idx %h, expected %h", $time, got, exp);
    end
  endtask : cmp_smp

  // Every accepted sample must be the oldest one handed to the transmitter
  // Looked at mid-cycle, where valid and ready stand settled for the coming edge
  always @(negedge core_clk) begin
    if (s_valid === 1'b1 && s_ready === 1'b1) begin
      cmp_smp({s_data, s_conv, s_idx}, (expq.size() != 0) ? expq.pop_front() : 27'hXXXXXXX);
    end
  end

  task automatic give_verdict();
    $display("%0d checks made, %0d mismatches", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic endt(input string nm);
    $display("test %s done at %0t", nm, $time);
  endtask : endt

  // Strobes drop one edge before the next task raises them again
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd

  task automatic cfg(input jtd_row_t r);
    t_lm1 = 3'(r.l - 1);
    t_fm1 = 3'(r.f - 1);
    t_mm1 = 8'(r.m - 1);
    t_sm1 = 3'(r.s - 1);
    t_npm1 = 5'(r.np - 1);
    wr(ADDR_MODE, r.mode);
    wr(ADDR_LM1, 8'(r.l - 1));
    wr(ADDR_FM1, 8'(r.f - 1));
    wr(ADDR_KM1, 8'h1F);
    wr(ADDR_MM1, 8'(r.m - 1));
    wr(ADDR_NM1, 8'(r.n - 1));
    wr(ADDR_NPM1, 8'(r.np - 1));
    wr(ADDR_SV, 8'(r.s - 1) | 8'h20);
    wr(ADDR_HD, 8'h80);
    wr(ADDR_DID, 8'h5A);
    wr(ADDR_LANE_ZERO_IDENTIFIER_MATCH, 8'h03);
    wr(ADDR_DESKEW, 8'((1 << r.l) - 1));
  endtask : cfg

  // Samples back to back; low bits are non-zero so truncation shows
  task automatic feed(input int n, input logic [15:0] msk, input int ms, input int s);
    @(posedge core_clk);
    for (int j = 0; j < n; j++) begin
      #1 t_smp = 16'(j) * 16'h9E37 + 16'h1C5B;
      t_valid = 1'b1;
      // Ready is read off the edge, so the value seen is the one the edge will use
      while (tx_ready !== 1'b1) begin
        @(posedge core_clk);
        #1;
      end
      @(posedge core_clk);
      expq.push_back({t_smp & msk, 8'(j % ms / s), 3'(j % s)});
    end
    #1 t_valid = 1'b0;
  endtask : feed

  task automatic drain();
    for (int w = 0; w < 3000 && expq.size() != 0; w++) @(posedge core_clk);
    #1 cmp_reg(8'(expq.size()), 8'h00);
  endtask : drain

  task automatic chk_rst();
    cmp_reg(lane_en, 8'h00);
    cmp_reg(lane_pd, 8'h00);
    cmp_reg({4'h0, reg_rvalid, s_valid, cfg_ok, tx_ready}, 8'h00);
    cmp_reg(reg_rdata | jtd_link_if_inst.ready, 8'h00);
  endtask : chk_rst

  // Hang guard: the whole sequence needs well under this many cycles
  initial begin
    #(20000 * 100);
    fails++;
    $display("Error at %0t: run did not finish", $time);
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    #1 chk_rst();
    rst_n = 1'b1;
    foreach (rows[i]) begin
      cfg(rows[i]);
      @(posedge core_clk);
      #1 cmp_reg({7'h00, cfg_ok}, 8'h01);
      cmp_reg(lane_en, 8'((1 << rows[i].l) - 1));
      rd(ADDR_PAGE, v);
      cmp_reg(v, 8'h80);
      feed(2 * rows[i].m * rows[i].s, 16'hFFFF << (16 - rows[i].n), rows[i].m * rows[i].s, rows[i].s);
      drain();
      endt("mode row");
    end
    cfg(rows[0]);
    foreach (bad[i]) begin
      wr(bad[i][27:16], bad[i][15:8]);
      @(posedge core_clk);
      #1 cmp_reg({7'h00, cfg_ok}, 8'h00);
      wr(bad[i][27:16], bad[i][7:0]);
      @(posedge core_clk);
      #1 cmp_reg({7'h00, cfg_ok}, 8'h01);
    end
    endt("bad set");
    wr(ADDR_MODE, 8'h83);
    @(posedge core_clk);
    #1 cmp_reg({7'h00, cfg_ok}, 8'h01);
    cmp_reg(lane_en, 8'h33);
    feed(4, 16'hFFFF, 2, 1);
    drain();
    wr(ADDR_MODE, 8'h03);
    endt("dual link");
    wr(12'h7FF, 8'hFF);
    rd(12'h7FF, v);
    cmp_reg(v, 8'h00);
    wr(ADDR_LANE_ZERO_IDENTIFIER_MATCH, 8'hFF);
    rd(ADDR_LANE_ZERO_IDENTIFIER_MATCH, v);
    cmp_reg(v, 8'h1F);
    endt("unmapped and reserved");
    wr(ADDR_PAGE, 8'h04);
    wr(ADDR_DESKEW, 8'h0F);
    rd(ADDR_DESKEW, v);
    cmp_reg(v, 8'h0F);
    rd(ADDR_PAGE, v);
    cmp_reg(v, 8'h84);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_DESKEW, v);
    cmp_reg(v, 8'h03);
    feed(4, 16'hFFFF, 2, 1);
    drain();
    endt("link page");
    wr(ADDR_LANE_PD, 8'h02);
    @(posedge core_clk);
    #1 cmp_reg(lane_pd, 8'h02);
    rst_n = 1'b0;
    @(posedge core_clk);
    #1 chk_rst();
    rst_n = 1'b1;
    rd(ADDR_MODE, v);
    cmp_reg(v, 8'h00);
    endt("power down and reset");
    give_verdict();
  end
endmodule : tb_jesd_transport_deframer
